// [pkg/reset_cause_pkg.sv]
// Package for the reset-cause flag register block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one system clock.
package reset_cause_pkg;

    // Register byte offsets
    localparam logic [3:0] flags_offset  = 4'h0;
    localparam logic [3:0] status_offset = 4'h4;
    localparam logic [3:0] mask_offset   = 4'h8;
    localparam logic [3:0] config_offset = 4'hc;

    // Field positions of the reset-cause register, then the enable bit of the config register
    localparam int stack_over_bit  = 7;
    localparam int stack_under_bit = 6;
    localparam int unused_bit      = 5;
    localparam int watchdog_bit    = 4;
    localparam int pin_reset_bit   = 3;
    localparam int reset_instr_bit = 2;
    localparam int power_on_bit    = 1;
    localparam int brown_out_bit   = 0;
    localparam int stack_enable_bit = 0;

    // Implemented bits of the flag, status and mask registers
    localparam logic [7:0] implemented_mask = 8'hdf;
    localparam logic [7:0] event_mask       = 8'hdd;

    // Reset values; power-on leaves both supply flags cleared
    localparam logic [7:0] flags_reset_value  = 8'h1c;
    localparam logic [7:0] status_reset_value = 8'h00;
    localparam logic [7:0] mask_reset_value   = 8'h00;
    localparam logic       stack_enable_reset = 1'h0;

    // Bus access states
    typedef enum logic [0:0] {
        bus_idle_state = 1'b0,
        bus_ack_state  = 1'b1
    } bus_state_type;

    // Zero-extends a byte onto the 32-bit data bus
    function automatic logic [31:0] widen_byte(input logic [7:0] value);
        widen_byte = {24'h000000, value};
    endfunction

endpackage

// [hdl/level_sync.sv]
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes inputs come from pins or detectors outside the clock domain.
module level_sync
    import reset_cause_pkg::*;
#(
    parameter int width = 1
)
(
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [width-1:0] async_in,
    output logic      [width-1:0] sync_out
);

    logic [width-1:0] first_stage;

    // The first stage feeds only the second
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            first_stage <= '0;
            sync_out    <= '0;
        end
        else
        begin
            first_stage <= async_in;
            sync_out    <= first_stage;
        end
    end

endmodule

// [hdl/flag_cell.sv]
// One hardware-set or hardware-cleared flag bit with firmware write access.
// Assumes event and force inputs are already in the clock domain.
module flag_cell
    import reset_cause_pkg::*;
#(
    parameter logic reset_value = 1'b0,
    parameter logic event_value = 1'b0,
    parameter logic force_value = 1'b0
)
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic hw_event,
    input  wire logic force_en,
    input  wire logic write_en,
    input  wire logic write_value,
    output logic      flag
);

    logic next_flag;

    // Hardware always beats firmware so no reset cause is lost
    always_comb
    begin
        next_flag = flag;
        if (force_en)
            next_flag = force_value;
        else if (hw_event)
            next_flag = event_value;
        else if (write_en)
            next_flag = write_value;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            flag <= reset_value;
        else
            flag <= next_flag;
    end

endmodule

// [hdl/reset_cause_flags_top.sv]
// Reset-cause flag register with an Avalon-MM slave, event interrupt and stack-reset gating.
// Assumes rst_n is the power-on reset; pin and brown-out detector inputs are asynchronous,
// the other event inputs are single-clock levels from logic on the same clock.

// Contract
// - Bit 7 overflow, 6 underflow, 5 unused, 4..0 watchdog, pin, instruction, power-on, brown-out.
// - Stack overflow sets its flag; reads zero until then or after firmware clears it.
// - Stack underflow sets its flag; reads zero until then or after firmware clears it.
// - Bit 5 always reads zero whatever firmware writes.
// - Watchdog reset clears its flag; otherwise it reads one, also after firmware writes one.
// - External pin reset clears its flag; otherwise it holds one until firmware changes it.
// - Reset instruction clears its flag; otherwise it reads one, firmware may write one.
// - Power-on reset clears the power-on flag; firmware writes it back to one.
// - Brown-out reset clears its flag; firmware sets it after power-on or brown-out.
// - Power-on and brown-out force stack flags to zero and three reset flags to one.
// - Implemented flags are read/write; hardware only sets stack flags, only clears others.
// - Both brown-out detectors are ORed into one brown-out signal clearing the flag.
// - Stack resets happen only when the stack-reset enable bit is set.
module reset_cause_flags_top
    import reset_cause_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic             irq,
    input  wire logic        stack_overflow_event,
    input  wire logic        stack_underflow_event,
    input  wire logic        watchdog_reset_event,
    input  wire logic        reset_instr_event,
    input  wire logic        external_reset_pin_n,
    input  wire logic        brown_out_detector,
    input  wire logic        low_power_brownout_detector,
    output logic             stack_reset_request,
    output logic [7:0]       reset_cause_flags
);

    logic [2:0]    async_levels;
    logic [2:0]    synced_levels;
    logic          pin_reset_event;
    logic          brown_out_event;
    logic          stack_over_hit;
    logic          stack_under_hit;
    logic [7:0]    flag_bits;
    logic [7:0]    event_bits;
    logic          flags_write;
    logic          status_write;
    logic          mask_write;
    logic          config_write;
    logic          access_now;

    bus_state_type bus_state;
    bus_state_type next_bus_state;
    logic          next_waitrequest;
    logic [31:0]   next_readdata;

    logic [7:0]    status;
    logic [7:0]    next_status;
    logic [7:0]    mask;
    logic [7:0]    next_mask;
    logic          stack_reset_enable;
    logic          next_stack_reset_enable;
    logic          next_irq;
    logic          next_stack_reset_request;
    logic [7:0]    next_reset_cause_flags;

    // Pin and detector levels cross into the clock domain first
    assign async_levels = {~external_reset_pin_n, brown_out_detector, low_power_brownout_detector};

    level_sync #(
        .width (3)
    ) sync_inst (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in (async_levels),
        .sync_out (synced_levels)
    );

    assign pin_reset_event = synced_levels[2];
    assign brown_out_event = synced_levels[1] | synced_levels[0];

    // Stack faults only count as resets while enabled
    assign stack_over_hit  = stack_overflow_event & stack_reset_enable;
    assign stack_under_hit = stack_underflow_event & stack_reset_enable;

    // A write takes effect on the edge where waitrequest is seen low
    assign access_now   = (bus_state == bus_ack_state);
    assign flags_write  = access_now & write & byteenable[0] & (address == flags_offset);
    assign status_write = access_now & write & byteenable[0] & (address == status_offset);
    assign mask_write   = access_now & write & byteenable[0] & (address == mask_offset);
    assign config_write = access_now & write & byteenable[0] & (address == config_offset);

    // Stack flags: hardware only sets them, brown-out forces them low
    flag_cell #(
        .reset_value (flags_reset_value[stack_over_bit]),
        .event_value (1'b1),
        .force_value (1'b0)
    ) stack_over_cell (
        .clock       (clock),
        .rst_n       (rst_n),
        .hw_event    (stack_over_hit),
        .force_en    (brown_out_event),
        .write_en    (flags_write),
        .write_value (writedata[stack_over_bit]),
        .flag        (flag_bits[stack_over_bit])
    );

    flag_cell #(
        .reset_value (flags_reset_value[stack_under_bit]),
        .event_value (1'b1),
        .force_value (1'b0)
    ) stack_under_cell (
        .clock       (clock),
        .rst_n       (rst_n),
        .hw_event    (stack_under_hit),
        .force_en    (brown_out_event),
        .write_en    (flags_write),
        .write_value (writedata[stack_under_bit]),
        .flag        (flag_bits[stack_under_bit])
    );

    assign flag_bits[unused_bit] = 1'b0;

    // Reset flags: hardware only clears them, brown-out forces them high
    flag_cell #(
        .reset_value (flags_reset_value[watchdog_bit]),
        .event_value (1'b0),
        .force_value (1'b1)
    ) watchdog_cell (
        .clock       (clock),
        .rst_n       (rst_n),
        .hw_event    (watchdog_reset_event),
        .force_en    (brown_out_event),
        .write_en    (flags_write),
        .write_value (writedata[watchdog_bit]),
        .flag        (flag_bits[watchdog_bit])
    );

    flag_cell #(
        .reset_value (flags_reset_value[pin_reset_bit]),
        .event_value (1'b0),
        .force_value (1'b1)
    ) pin_reset_cell (
        .clock       (clock),
        .rst_n       (rst_n),
        .hw_event    (pin_reset_event),
        .force_en    (brown_out_event),
        .write_en    (flags_write),
        .write_value (writedata[pin_reset_bit]),
        .flag        (flag_bits[pin_reset_bit])
    );

    flag_cell #(
        .reset_value (flags_reset_value[reset_instr_bit]),
        .event_value (1'b0),
        .force_value (1'b1)
    ) reset_instr_cell (
        .clock       (clock),
        .rst_n       (rst_n),
        .hw_event    (reset_instr_event),
        .force_en    (brown_out_event),
        .write_en    (flags_write),
        .write_value (writedata[reset_instr_bit]),
        .flag        (flag_bits[reset_instr_bit])
    );

    // Power-on flag is cleared by rst_n itself; brown-out leaves it alone
    flag_cell #(
        .reset_value (flags_reset_value[power_on_bit]),
        .event_value (1'b0),
        .force_value (1'b0)
    ) power_on_cell (
        .clock       (clock),
        .rst_n       (rst_n),
        .hw_event    (1'b0),
        .force_en    (1'b0),
        .write_en    (flags_write),
        .write_value (writedata[power_on_bit]),
        .flag        (flag_bits[power_on_bit])
    );

    flag_cell #(
        .reset_value (flags_reset_value[brown_out_bit]),
        .event_value (1'b0),
        .force_value (1'b0)
    ) brown_out_cell (
        .clock       (clock),
        .rst_n       (rst_n),
        .hw_event    (brown_out_event),
        .force_en    (1'b0),
        .write_en    (flags_write),
        .write_value (writedata[brown_out_bit]),
        .flag        (flag_bits[brown_out_bit])
    );

    // Event layout matches the flag layout; power-on cannot be seen after rst_n
    always_comb
    begin
        event_bits                  = 8'h00;
        event_bits[stack_over_bit]  = stack_over_hit;
        event_bits[stack_under_bit] = stack_under_hit;
        event_bits[watchdog_bit]    = watchdog_reset_event;
        event_bits[pin_reset_bit]   = pin_reset_event;
        event_bits[reset_instr_bit] = reset_instr_event;
        event_bits[brown_out_bit]   = brown_out_event;
    end

    // Bus slave: every access answers on the second edge
    always_comb
    begin
        next_bus_state   = bus_idle_state;
        next_waitrequest = 1'b1;
        next_readdata    = readdata;
        case (bus_state)
            bus_idle_state:
            begin
                if (read | write)
                begin
                    next_bus_state   = bus_ack_state;
                    next_waitrequest = 1'b0;
                    next_readdata    = 32'h00000000;
                    if (read)
                    begin
                        case (address)
                            flags_offset:  next_readdata = widen_byte(flag_bits & implemented_mask);
                            status_offset: next_readdata = widen_byte(status);
                            mask_offset:   next_readdata = widen_byte(mask);
                            config_offset: next_readdata = widen_byte({7'h00, stack_reset_enable});
                            default:       next_readdata = 32'h00000000;
                        endcase
                    end
                end
            end
            bus_ack_state:
            begin
                next_bus_state   = bus_idle_state;
                next_waitrequest = 1'b1;
            end
            default:
            begin
                next_bus_state   = bus_idle_state;
                next_waitrequest = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_state   <= bus_idle_state;
            waitrequest <= 1'b1;
            readdata    <= 32'h00000000;
        end
        else
        begin
            bus_state   <= next_bus_state;
            waitrequest <= next_waitrequest;
            readdata    <= next_readdata;
        end
    end

    // Interrupt status, mask, configuration and registered outputs
    always_comb
    begin
        next_status = status;
        if (status_write)
            next_status = status & ~writedata[7:0];
        // A new event wins over a clear in the same cycle
        next_status = (next_status | event_bits) & event_mask;

        next_mask = mask;
        if (mask_write)
            next_mask = writedata[7:0] & event_mask;

        next_stack_reset_enable = stack_reset_enable;
        if (config_write)
            next_stack_reset_enable = writedata[stack_enable_bit];

        next_irq                 = |(next_status & next_mask);
        next_stack_reset_request = stack_over_hit | stack_under_hit;
        next_reset_cause_flags   = flag_bits & implemented_mask;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status              <= status_reset_value;
            mask                <= mask_reset_value;
            stack_reset_enable  <= stack_enable_reset;
            irq                 <= 1'b0;
            stack_reset_request <= 1'b0;
            reset_cause_flags   <= flags_reset_value;
        end
        else
        begin
            status              <= next_status;
            mask                <= next_mask;
            stack_reset_enable  <= next_stack_reset_enable;
            irq                 <= next_irq;
            stack_reset_request <= next_stack_reset_request;
            reset_cause_flags   <= next_reset_cause_flags;
        end
    end

endmodule

// [test/reset_cause_chk.sv]
// Concurrent checks on the ports of the reset-cause flag register block.
// Assumes the package constants and the bus and event timing of the block.
module reset_cause_chk
    import reset_cause_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [3:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        irq,
    input wire logic        stack_overflow_event,
    input wire logic        stack_underflow_event,
    input wire logic        watchdog_reset_event,
    input wire logic        reset_instr_event,
    input wire logic        external_reset_pin_n,
    input wire logic        brown_out_detector,
    input wire logic        low_power_brownout_detector,
    input wire logic        stack_reset_request,
    input wire logic [7:0]  reset_cause_flags
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_taken;
        (read || write) && waitrequest;
    endsequence
    sequence s_supply_drop;
        brown_out_detector || low_power_brownout_detector;
    endsequence

    a_unused_zero: assert property (reset_cause_flags[unused_bit] == 1'b0)
        else $error("unused flag bit reads one");
    a_bus_answer: assert property (s_taken |-> ##1 !waitrequest)
        else $error("bus request not answered after one cycle");
    a_answer_single: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_read_upper: assert property (!waitrequest |-> readdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    a_stack_gate: assert property (!(stack_overflow_event || stack_underflow_event) |=> !stack_reset_request)
        else $error("stack reset request without cause");
    a_over_sets: assert property (stack_reset_request && $past(stack_overflow_event) |=> reset_cause_flags[7])
        else $error("overflow flag not set");
    a_under_sets: assert property (stack_reset_request && $past(stack_underflow_event) |=> reset_cause_flags[6])
        else $error("underflow flag not set");
    a_watchdog_clears: assert property (watchdog_reset_event |=> ##1 !reset_cause_flags[4])
        else $error("watchdog flag not cleared");
    a_instr_clears: assert property (reset_instr_event |=> ##1 !reset_cause_flags[2])
        else $error("instruction flag not cleared");
    a_pin_clears: assert property (!external_reset_pin_n |-> ##[3:5] !reset_cause_flags[3])
        else $error("pin flag not cleared");
    a_supply_clears: assert property (s_supply_drop |-> ##[3:5] !reset_cause_flags[0])
        else $error("brown-out flag not cleared");
    a_supply_forces: assert property (s_supply_drop |-> ##[3:5] reset_cause_flags[7:2] == 6'b000111)
        else $error("brown-out did not force flags");
endmodule

bind reset_cause_flags_top reset_cause_chk i_reset_cause_chk (
    .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .irq(irq), .stack_overflow_event(stack_overflow_event), .stack_underflow_event(stack_underflow_event),
    .watchdog_reset_event(watchdog_reset_event), .reset_instr_event(reset_instr_event),
    .external_reset_pin_n(external_reset_pin_n), .brown_out_detector(brown_out_detector),
    .low_power_brownout_detector(low_power_brownout_detector),
    .stack_reset_request(stack_reset_request), .reset_cause_flags(reset_cause_flags)
);

// [test/tb.sv]
// Self-checking bench for the reset-cause flag register block.
// Assumes the bus answers by waitrequest; pin and detector inputs pass a 2-flop sync.
module tb
    import reset_cause_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock;
    logic        rst_n;
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        irq;
    logic        stack_reset_request;
    logic [7:0]  reset_cause_flags;
    logic [6:0]  ev;
    logic [7:0]  r;
    logic [7:0]  v;
    logic [31:0] q;
    int          bad_count;
    int          n_checks;
    int          req_cnt = 0;
    int          k;

    reset_cause_flags_top i_reset_cause_flags_top (
        .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .irq(irq), .stack_overflow_event(ev[0]), .stack_underflow_event(ev[1]),
        .watchdog_reset_event(ev[2]), .reset_instr_event(ev[3]), .external_reset_pin_n(!ev[4]),
        .brown_out_detector(ev[5]), .low_power_brownout_detector(ev[6]),
        .stack_reset_request(stack_reset_request), .reset_cause_flags(reset_cause_flags)
    );

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    always @(posedge clock)
        if (stack_reset_request === 1'b1)
            req_cnt <= req_cnt + 1;

    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask

    // Holds the request until waitrequest is sampled low, then releases it
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge clock);
        address <= a;
        writedata <= {24'h000000, d};
        byteenable <= be;
        write <= wr;
        read <= !wr;
        @(posedge clock);
        while (waitrequest !== 1'b0)
            @(posedge clock);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic rd(input string n, input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 4'h0);
        check(n, {24'h000000, e}, q);
    endtask

    // Event levels are held for several cycles so the synchronised inputs see them
    task automatic pulse(input int i, input int n);
        @(posedge clock);
        ev[i] <= 1'b1;
        repeat (n) @(posedge clock);
        ev[i] <= 1'b0;
    endtask

    function automatic logic [7:0] expect_after(input logic [7:0] f, input int i);
        logic [7:0] e;
        e = f;
        case (i)
            0: e[stack_over_bit] = 1'b1;
            1: e[stack_under_bit] = 1'b1;
            2: e[watchdog_bit] = 1'b0;
            3: e[reset_instr_bit] = 1'b0;
            4: e[pin_reset_bit] = 1'b0;
            default: e = {5'b00011, 1'b1, f[power_on_bit], 1'b0};
        endcase
        return e;
    endfunction

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        #(40 * 4000);
        bad_count++;
        stop_test();
    end

    initial
    begin
        rst_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 4'h0;
        writedata = 32'h00000000;
        byteenable = 4'h0;
        ev = 7'h00;
        bad_count = 0;
        n_checks = 0;
        r = 8'($urandom(32'h2d56));
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        check("flags out", 32'h1c, {24'h000000, reset_cause_flags});
        rd("flags", flags_offset, 8'h1c);
        rd("status", status_offset, 8'h00);
        rd("mask", mask_offset, 8'h00);
        rd("config", config_offset, 8'h00);
        $display("test reset done");
        wr(flags_offset, 8'hff);
        rd("flags", flags_offset, 8'hdf);
        wr(mask_offset, 8'hff);
        rd("mask", mask_offset, 8'hdd);
        wr(mask_offset, 8'h00);
        bus(1'b1, flags_offset, 8'h00, 4'h0);
        wr(4'h1, 8'h00);
        rd("unmapped", 4'h1, 8'h00);
        rd("flags", flags_offset, 8'hdf);
        repeat (6)
        begin
            r = 8'($urandom);
            wr(flags_offset, r);
            rd("flags", flags_offset, r & 8'hdf);
        end
        $display("test registers done");
        wr(flags_offset, 8'h1c);
        k = req_cnt;
        pulse(0, 2);
        pulse(1, 2);
        repeat (4) @(posedge clock);
        rd("flags", flags_offset, 8'h1c);
        check("request", 32'(k), 32'(req_cnt));
        rd("status", status_offset, 8'h00);
        $display("test stack gate done");
        wr(config_offset, 8'h01);
        for (int i = 0; i < 7; i++)
        begin
            r = 8'($urandom);
            wr(flags_offset, r);
            k = req_cnt;
            pulse(i, 4);
            repeat (6) @(posedge clock);
            v = expect_after(r & 8'hdf, i);
            rd("flags", flags_offset, v);
            check("flags out", {24'h000000, v}, {24'h000000, reset_cause_flags});
            check("request", (i < 2) ? 1 : 0, (req_cnt > k) ? 1 : 0);
        end
        check("irq", 32'h0, {31'h0, irq});
        rd("status", status_offset, 8'hdd);
        wr(mask_offset, 8'h80);
        repeat (2) @(posedge clock);
        check("irq", 32'h1, {31'h0, irq});
        wr(status_offset, 8'h80);
        repeat (2) @(posedge clock);
        check("irq", 32'h0, {31'h0, irq});
        rd("status", status_offset, 8'h5d);
        $display("test events done");
        wr(flags_offset, 8'hdf);
        // Event stands only at the edge where the write lands, so a winning write would stay visible
        fork
            wr(flags_offset, 8'hdf);
            begin
                repeat (2) @(posedge clock);
                ev[2] <= 1'b1;
                @(posedge clock);
                ev[2] <= 1'b0;
            end
        join
        rd("flags", flags_offset, 8'hcf);
        wr(flags_offset, 8'hdf);
        rd("flags", flags_offset, 8'hdf);
        $display("test collision done");
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        check("flags out", 32'h1c, {24'h000000, reset_cause_flags});
        rd("flags", flags_offset, 8'h1c);
        rd("config", config_offset, 8'h00);
        $display("test second reset done");
        stop_test();
    end
endmodule
